// ===== hdl/pixel_lut_shading_pattern_path.sv
// Pixel path: test pattern, shading correction and colour lookup table
`timescale 1ns/100ps
`default_nettype none

module pixel_lut_shading_pattern_path #(
    parameter int SHADE_W = 64,
    parameter int SHADE_H = 48
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pixel_path_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pixel_path_pkg::pix_s pix_in,
    output pixel_path_pkg::pix_s pix_out
);

    localparam int DW = pixel_path_pkg::DATA_W;
    localparam int CW = pixel_path_pkg::COORD_W;
    localparam int SA_W = $clog2(SHADE_W * SHADE_H);
    localparam int TA_W = $clog2(pixel_path_pkg::TABLE_ENTRIES);

    // ****************************************
    // Checks
    // ****************************************
    if (SHADE_W < 1 || SHADE_H < 1 || SHADE_W >= (1 << CW) ||
        SHADE_H >= (1 << CW) || SHADE_W * SHADE_H < 2) begin : g_bad
        $error("Shading buffer size out of range");
    end

    // ****************************************
    // Register bus
    // ****************************************
    logic table_map_on;
    logic shading_fix_on;
    logic [pixel_path_pkg::PAT_W-1:0] pattern_choice;
    logic [TA_W-1:0] table_index;
    logic [SA_W-1:0] shade_index;
    logic [pixel_path_pkg::FRAME_W-1:0] frame_cnt;
    logic [31:0] read_data;
    logic hit;
    wire logic setup = psel & ~penable;
    wire logic wr_fire = psel & penable & pready & pwrite;
    wire logic wr_ctrl = wr_fire && paddr == pixel_path_pkg::REG_CTRL;
    wire logic wr_tidx = wr_fire && paddr == pixel_path_pkg::REG_TABLE_INDEX;
    wire logic wr_tdat = wr_fire && paddr == pixel_path_pkg::REG_TABLE_DATA;
    wire logic wr_sidx = wr_fire && paddr == pixel_path_pkg::REG_SHADE_INDEX;
    wire logic wr_sdat = wr_fire && paddr == pixel_path_pkg::REG_SHADE_DATA;
    wire logic shade_last = shade_index == SA_W'(SHADE_W * SHADE_H - 1);

    always_comb begin
        read_data = '0;
        hit = 1'b1;
        case (paddr)
            pixel_path_pkg::REG_CTRL: begin
                read_data[pixel_path_pkg::CTRL_TABLE_BIT] = table_map_on;
                read_data[pixel_path_pkg::CTRL_SHADE_BIT] = shading_fix_on;
                read_data[pixel_path_pkg::CTRL_PAT_LSB +:
                          pixel_path_pkg::PAT_W] = pattern_choice;
            end
            pixel_path_pkg::REG_STATUS: read_data = 32'(frame_cnt);
            pixel_path_pkg::REG_TABLE_INDEX: read_data = 32'(table_index);
            pixel_path_pkg::REG_SHADE_INDEX: read_data = 32'(shade_index);
            pixel_path_pkg::REG_TABLE_DATA: read_data = '0;
            pixel_path_pkg::REG_SHADE_DATA: read_data = '0;
            pixel_path_pkg::REG_TABLE_INFO:
                read_data = 32'(pixel_path_pkg::TABLE_ENTRIES);
            pixel_path_pkg::REG_SHADE_SIZE:
                read_data = {16'(SHADE_H), 16'(SHADE_W)};
            pixel_path_pkg::REG_SHADE_LIMITS:
                read_data = {pixel_path_pkg::OFFSET_CEILING,
                             pixel_path_pkg::OFFSET_FLOOR,
                             pixel_path_pkg::GAIN_CEILING,
                             pixel_path_pkg::GAIN_FLOOR};
            default: hit = 1'b0;
        endcase
    end

    // One wait-free access phase; answer registered during setup
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : read_data;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            table_map_on <= 1'b0;
            shading_fix_on <= 1'b0;
            pattern_choice <= pixel_path_pkg::PAT_OFF;
        end else if (wr_ctrl) begin
            table_map_on <= pwdata[pixel_path_pkg::CTRL_TABLE_BIT];
            shading_fix_on <= pwdata[pixel_path_pkg::CTRL_SHADE_BIT];
            pattern_choice <= pwdata[pixel_path_pkg::CTRL_PAT_LSB +:
                                     pixel_path_pkg::PAT_W];
        end
    end

    // array load, index steps per word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            table_index <= '0;
            shade_index <= '0;
        end else begin
            if (wr_tidx) begin
                table_index <= pwdata[TA_W-1:0];
            end else if (wr_tdat) begin
                table_index <= table_index + 1'b1;
            end
            if (wr_sidx) begin
                shade_index <= pwdata[SA_W-1:0];
            end else if (wr_sdat) begin
                shade_index <= shade_last ? '0 : shade_index + 1'b1;
            end
        end
    end

    // ****************************************
    // Test pattern generator
    // ****************************************
    logic [CW-1:0] x_cnt;
    logic [CW-1:0] y_cnt;
    wire logic [CW-1:0] cur_x = pix_in.sol ? '0 : x_cnt;
    wire logic [CW-1:0] cur_y =
        pix_in.sof ? '0 : (pix_in.sol ? y_cnt + 1'b1 : y_cnt);
    wire logic [pixel_path_pkg::FRAME_W-1:0] cur_f =
        pix_in.sof ? frame_cnt + 1'b1 : frame_cnt;
    wire logic [2:0] bar_colour =
        ~cur_x[pixel_path_pkg::BAR_SHIFT +: 3];
    logic [DW-1:0] grey;
    logic pat_on;
    pixel_path_pkg::pix_s gen_pix;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            x_cnt <= '0;
            y_cnt <= '0;
            frame_cnt <= '0;
        end else if (pix_in.valid) begin
            x_cnt <= cur_x + 1'b1;
            y_cnt <= cur_y;
            frame_cnt <= cur_f;
        end
    end

    always_comb begin
        pat_on = 1'b1;
        grey = '0;
        case (pattern_choice)
            pixel_path_pkg::PAT_HRAMP: grey = cur_x[DW-1:0];
            pixel_path_pkg::PAT_VRAMP: grey = cur_y[DW-1:0];
            pixel_path_pkg::PAT_DIAG:
                grey = cur_x[DW-1:0] + cur_y[DW-1:0] + cur_f[DW-1:0];
            pixel_path_pkg::PAT_PURITY: grey = cur_f[DW-1:0];
            pixel_path_pkg::PAT_COLOUR: grey = '0;
            default: pat_on = 1'b0;
        endcase
    end

    always_comb begin
        gen_pix = pix_in;
        for (int c = 0; c < pixel_path_pkg::CHANS; c++) begin
            if (pattern_choice == pixel_path_pkg::PAT_COLOUR) begin
                gen_pix.chan[c] = {DW{bar_colour[2-c]}};
            end else if (pat_on) begin
                gen_pix.chan[c] = grey;
            end
        end
    end

    // ****************************************
    // Shading correction
    // ****************************************
    pixel_path_pkg::pix_s s1;
    pixel_path_pkg::pix_s s2;
    pixel_path_pkg::pix_s s3;
    pixel_path_pkg::pix_s s4;
    pixel_path_pkg::pix_s next_s3;
    logic s1_in;
    logic s2_in;
    logic [SA_W-1:0] s1_addr;
    logic [pixel_path_pkg::COEF_W-1:0] coef;
    wire logic in_buf = cur_x < CW'(SHADE_W) && cur_y < CW'(SHADE_H);
    wire logic [SA_W-1:0] pix_addr = SA_W'(cur_y * SHADE_W + cur_x);
    wire logic [DW-1:0] gain = coef[pixel_path_pkg::GAIN_LSB +: DW];
    wire logic [DW-1:0] offset = coef[pixel_path_pkg::OFFSET_LSB +: DW];
    wire logic use_shade = shading_fix_on & s2_in;

    coef_mem #(.WIDTH(pixel_path_pkg::COEF_W), .DEPTH(SHADE_W * SHADE_H),
               .AW(SA_W)) u_shade (
        .clk(clk),
        .wr_en(wr_sdat),
        .wr_addr(shade_index),
        .wr_data(pwdata[pixel_path_pkg::COEF_W-1:0]),
        .rd_addr(s1_addr),
        .rd_data(coef)
    );

    always_comb begin
        logic [DW-1:0] diff;
        logic [2*DW-1:0] prod;
        logic [2*DW-1:0] scaled;
        diff = '0;
        prod = '0;
        scaled = '0;
        next_s3 = s2;
        for (int c = 0; c < pixel_path_pkg::CHANS; c++) begin
            diff = s2.chan[c] > offset ? s2.chan[c] - offset : '0;
            prod = diff * gain;
            scaled = prod >> pixel_path_pkg::GAIN_SHIFT;
            if (use_shade) begin
                next_s3.chan[c] = scaled > (2*DW)'(pixel_path_pkg::PIX_MAX) ?
                    pixel_path_pkg::PIX_MAX : scaled[DW-1:0];
            end
        end
    end

    // ****************************************
    // Colour lookup table
    // ****************************************
    logic [pixel_path_pkg::CHANS-1:0][DW-1:0] mapped;

    for (genvar c = 0; c < pixel_path_pkg::CHANS; c++) begin : g_table
        coef_mem #(.WIDTH(DW), .DEPTH(pixel_path_pkg::TABLE_ENTRIES),
                   .AW(TA_W)) u_table (
            .clk(clk),
            .wr_en(wr_tdat),
            .wr_addr(table_index),
            .wr_data(pwdata[c*DW +: DW]),
            .rd_addr(s3.chan[c]),
            .rd_data(mapped[c])
        );
    end

    // ****************************************
    // Pipeline registers
    // ****************************************
    // Flag and data bits of every stage reset to zero, except the coef_mem read registers (coef, mapped), which have no reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            s4 <= '0;
            pix_out <= '0;
            s1_in <= 1'b0;
            s2_in <= 1'b0;
            s1_addr <= '0;
        end else begin
            s1 <= gen_pix;
            s1_in <= in_buf;
            s1_addr <= pix_addr;
            s2 <= s1;
            s2_in <= s1_in;
            s3 <= next_s3;
            s4 <= s3;
            pix_out <= s4;
            if (table_map_on) begin
                pix_out.chan <= mapped;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    wire logic bypass_all = !table_map_on && !shading_fix_on &&
        pattern_choice == pixel_path_pkg::PAT_OFF;

    // History older than the last reset is not the pipeline's own
    logic [2:0] fill_cnt;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fill_cnt <= '0;
        end else if (fill_cnt != 3'(pixel_path_pkg::PIPE_LAT)) begin
            fill_cnt <= fill_cnt + 1'b1;
        end
    end

    property p_latency;
        @(posedge clk) disable iff (sys_rst)
        fill_cnt == 3'(pixel_path_pkg::PIPE_LAT) |->
        pix_out.valid == $past(pix_in.valid, 5);
    endproperty
    a_latency: assert property (p_latency)
        else $error("Output valid not five cycles after input");

    property p_bypass;
        @(posedge clk) disable iff (sys_rst)
        bypass_all [*6] |-> pix_out.chan == $past(pix_in.chan, 5);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("Bypassed pixel changed");

    property p_hramp_start;
        @(posedge clk) disable iff (sys_rst)
        pix_in.valid && pix_in.sol &&
        pattern_choice == pixel_path_pkg::PAT_HRAMP |=> s1.chan[0] == '0;
    endproperty
    a_hramp_start: assert property (p_hramp_start)
        else $error("Horizontal ramp not zero at line start");

    property p_vramp_start;
        @(posedge clk) disable iff (sys_rst)
        pix_in.valid && pix_in.sof &&
        pattern_choice == pixel_path_pkg::PAT_VRAMP |=> s1.chan[1] == '0;
    endproperty
    a_vramp_start: assert property (p_vramp_start)
        else $error("Vertical ramp not zero at frame start");

    property p_first_bar;
        @(posedge clk) disable iff (sys_rst)
        pix_in.valid && pix_in.sol &&
        pattern_choice == pixel_path_pkg::PAT_COLOUR |=>
        s1.chan[2] == pixel_path_pkg::PIX_MAX;
    endproperty
    a_first_bar: assert property (p_first_bar)
        else $error("First colour bar wrong");

    property p_ctrl_write;
        @(posedge clk) disable iff (sys_rst)
        wr_ctrl |=> shading_fix_on == $past(pwdata[1]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Shading enable not taken from write");

    property p_index_step;
        @(posedge clk) disable iff (sys_rst)
        wr_tdat |=> table_index == $past(table_index) + 1'b1;
    endproperty
    a_index_step: assert property (p_index_step)
        else $error("Table index did not advance");

    property p_size_read;
        @(posedge clk) disable iff (sys_rst)
        setup && !pwrite && paddr == pixel_path_pkg::REG_SHADE_SIZE |=>
        pready && prdata == {16'(SHADE_H), 16'(SHADE_W)};
    endproperty
    a_size_read: assert property (p_size_read)
        else $error("Buffer size read wrong");

    property p_clip_low;
        @(posedge clk) disable iff (sys_rst)
        use_shade && s2.chan[0] <= offset |=> s3.chan[0] == '0;
    endproperty
    a_clip_low: assert property (p_clip_low)
        else $error("Correction below offset not clipped to zero");

    c_hramp: cover property (@(posedge clk) disable iff (sys_rst)
        pix_in.valid && pattern_choice == pixel_path_pkg::PAT_HRAMP);
    c_colour: cover property (@(posedge clk) disable iff (sys_rst)
        pix_in.valid && pattern_choice == pixel_path_pkg::PAT_COLOUR);
    c_mapped: cover property (@(posedge clk) disable iff (sys_rst)
        table_map_on && pix_out.valid);
    c_shaded: cover property (@(posedge clk) disable iff (sys_rst)
        use_shade && s2.valid);

endmodule // pixel_lut_shading_pattern_path

`default_nettype wire

// ===== common/pixel_path_pkg.sv
// Shared constants and carriers for the pixel lookup, shading and pattern path
package pixel_path_pkg;

    // ****************************************
    // Pixel data and stream carrier
    // ****************************************
    localparam int DATA_W = 8;
    localparam int CHANS = 3;
    localparam int COORD_W = 12;
    localparam int FRAME_W = 16;
    localparam int PIPE_LAT = 5;

    // Channel 0 red, 1 green, 2 blue
    typedef struct packed {
        logic valid;
        logic sof;
        logic sol;
        logic [CHANS-1:0][DATA_W-1:0] chan;
    } pix_s;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TABLE_INDEX = 8'h08;
    localparam logic [ADDR_W-1:0] REG_TABLE_DATA = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_SHADE_INDEX = 8'h10;
    localparam logic [ADDR_W-1:0] REG_SHADE_DATA = 8'h14;
    localparam logic [ADDR_W-1:0] REG_TABLE_INFO = 8'h18;
    localparam logic [ADDR_W-1:0] REG_SHADE_SIZE = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_SHADE_LIMITS = 8'h20;

    // Control register fields
    localparam int CTRL_TABLE_BIT = 0;
    localparam int CTRL_SHADE_BIT = 1;
    localparam int CTRL_PAT_LSB = 4;
    localparam int PAT_W = 3;

    // Coefficient word fields: gain above offset
    localparam int COEF_W = 2 * DATA_W;
    localparam int GAIN_LSB = DATA_W;
    localparam int OFFSET_LSB = 0;

    // ****************************************
    // Pattern codes
    // ****************************************
    localparam logic [PAT_W-1:0] PAT_OFF = 3'h0;
    localparam logic [PAT_W-1:0] PAT_HRAMP = 3'h1;
    localparam logic [PAT_W-1:0] PAT_VRAMP = 3'h2;
    localparam logic [PAT_W-1:0] PAT_DIAG = 3'h3;
    localparam logic [PAT_W-1:0] PAT_PURITY = 3'h4;
    localparam logic [PAT_W-1:0] PAT_COLOUR = 3'h5;

    // ****************************************
    // Table and shading figures
    // ****************************************
    localparam int TABLE_ENTRIES = 256;
    localparam int BAR_SHIFT = 6;
    localparam int GAIN_SHIFT = 7;
    localparam logic [DATA_W-1:0] GAIN_FLOOR = 8'h00;
    localparam logic [DATA_W-1:0] GAIN_CEILING = 8'hff;
    localparam logic [DATA_W-1:0] OFFSET_FLOOR = 8'h00;
    localparam logic [DATA_W-1:0] OFFSET_CEILING = 8'hff;
    localparam logic [DATA_W-1:0] PIX_MAX = 8'hff;

endpackage

// ===== hdl/coef_mem.sv
// Single write port, single registered read port memory
`timescale 1ns/100ps
`default_nettype none

module coef_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    // ****************************************
    // Checks
    // ****************************************
    if (DEPTH < 2 || DEPTH > (1 << AW) || WIDTH < 1) begin : g_bad
        $error("coef_mem: depth or width out of range");
    end

    // No reset: contents hold until power is removed
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
        rd_data <= store[rd_addr];
    end

endmodule // coef_mem

`default_nettype wire

// ===== verification/sensor_source.sv
// Converter-side model that feeds raw frames into the pixel path
`timescale 1ns/100ps
`default_nettype none

module sensor_source #(
    parameter int LINE_W = 264,
    parameter int LINES = 3
) (
    input wire logic clk,
    output pixel_path_pkg::pix_s pix
);
    int seed = 27791;
    logic busy = 1'b0;

    // ****************************************
    // Idle noise
    // ****************************************
    // Between frames the lines carry noise, so stale data never looks valid
    initial pix = '0;
    always @(posedge clk) if (!busy) pix <= {3'b000, 24'($random(seed))};

    // ****************************************
    // Frame sender
    // ****************************************
    task automatic send_frame(input logic gaps);
        busy = 1'b1;
        for (int y = 0; y < LINES; y++) begin
            for (int x = 0; x < LINE_W; x++) begin
                while (gaps && $random(seed) % 4 == 0) begin
                    @(posedge clk);
                    pix <= {3'b000, 24'($random(seed))};
                end
                @(posedge clk);
                pix <= {1'b1, x == 0 && y == 0, x == 0, 24'($random(seed))};
            end
        end
        @(posedge clk);
        pix <= {3'b000, 24'($random(seed))};
        busy = 1'b0;
    endtask
endmodule // sensor_source

`default_nettype wire

// ===== verification/pixel_lut_shading_pattern_path_tb_top.sv
// Self-checking bench for the pixel lookup, shading and pattern path
`timescale 1ns/100ps
`default_nettype none

module pixel_lut_shading_pattern_path_tb_top;
    localparam int SW = 8;
    localparam int SH = 2;
    localparam int PER = 50;
    typedef struct { pixel_path_pkg::pix_s p; time t; } note_s;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [pixel_path_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, w, ctrl;
    pixel_path_pkg::pix_s pix_in, pix_out;
    logic [7:0] tbl [3][256];
    logic [7:0] gain [SW*SH];
    logic [7:0] offs [SW*SH];
    logic [15:0] frames;
    int seed = 27791;
    int failures = 0;
    int num_checks = 0;
    int x, y;
    note_s q[$];

    pixel_lut_shading_pattern_path #(.SHADE_W(SW), .SHADE_H(SH)) dut (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pix_in(pix_in),
        .pix_out(pix_out));
    sensor_source src (.clk(clk), .pix(pix_in));

    initial begin
        clk = 1'b0;
        forever #(PER / 2) clk = ~clk;
    end

    // ****************************************
    // Reference model and compares
    // ****************************************
    function automatic pixel_path_pkg::pix_s model(pixel_path_pkg::pix_s p);
        logic [7:0] g;
        logic [2:0] pat;
        int a;
        int r;
        pat = ctrl[6:4];
        a = y * SW + x;
        g = pat == pixel_path_pkg::PAT_HRAMP ? 8'(x) :
            pat == pixel_path_pkg::PAT_VRAMP ? 8'(y) :
            pat == pixel_path_pkg::PAT_DIAG ? 8'(x + y + frames) : frames[7:0];
        for (int c = 0; c < 3; c++) begin
            if (pat == pixel_path_pkg::PAT_COLOUR) p.chan[c] = {8{~x[8-c]}};
            else if (pat != 0 && pat <= pixel_path_pkg::PAT_PURITY)
                p.chan[c] = g;
            if (ctrl[1] && x < SW && y < SH) begin
                r = p.chan[c] > offs[a] ?
                    (p.chan[c] - offs[a]) * gain[a] >> 7 : 0;
                p.chan[c] = r > 255 ? 8'hff : 8'(r);
            end
            if (ctrl[0]) p.chan[c] = tbl[c][p.chan[c]];
        end
        return p;
    endfunction

    task automatic fail(input string m);
        failures++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task automatic check_word(input logic [31:0] e, input logic ee);
        num_checks++;
        if (rd !== e || err !== ee)
            fail($sformatf("read %h expected %h", rd, e));
    endtask

    task automatic check_pix(input note_s n);
        num_checks++;
        if (pix_out !== n.p || $time - n.t != PER * pixel_path_pkg::PIPE_LAT)
            fail($sformatf("pixel %h expected %h", pix_out, n.p));
    endtask

    // Sensor side notes each expected pixel as it enters
    always @(posedge clk) begin
        if (!sys_rst && pix_in.valid) begin
            if (pix_in.sof) begin
                frames++;
                y = 0;
                x = 0;
            end else if (pix_in.sol) begin
                y++;
                x = 0;
            end
            q.push_back('{model(pix_in), $time});
            x++;
        end
    end

    always @(posedge clk) begin
        if (!sys_rst && pix_out.valid === 1'b1) begin
            if (q.size() == 0) fail("unexpected pixel");
            else check_pix(q.pop_front());
        end
    end

    // ****************************************
    // Register bus master
    // ****************************************
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait states are the slave's business; the watchdog ends a hang
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic ee);
        apb(1'b0, a, 32'h0);
        check_word(e, ee);
    endtask

    task automatic drain;
        for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clk);
        num_checks++;
        if (q.size() != 0) fail("pixels lost");
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        complete_run;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, ctrl, frames} = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk(pixel_path_pkg::REG_CTRL, 32'h0, 1'b0);
        rd_chk(pixel_path_pkg::REG_TABLE_INFO, 32'h100, 1'b0);
        rd_chk(pixel_path_pkg::REG_SHADE_SIZE,
               {16'(SH), 16'(SW)}, 1'b0);
        rd_chk(pixel_path_pkg::REG_SHADE_LIMITS, 32'hff00ff00, 1'b0);
        rd_chk(8'h40, 32'h0, 1'b1);
        $display("test 0 done");
        // One write past the end checks the pointer wrap
        apb(1'b1, pixel_path_pkg::REG_TABLE_INDEX, 32'h0);
        for (int i = 0; i <= 256; i++) begin
            w = $random(seed);
            for (int c = 0; c < 3; c++) tbl[c][i % 256] = w[8*c +: 8];
            apb(1'b1, pixel_path_pkg::REG_TABLE_DATA, w);
        end
        apb(1'b1, pixel_path_pkg::REG_SHADE_INDEX, 32'h0);
        for (int i = 0; i <= SW * SH; i++) begin
            w = $random(seed);
            gain[i % (SW * SH)] = w[15:8];
            offs[i % (SW * SH)] = w[7:0];
            apb(1'b1, pixel_path_pkg::REG_SHADE_DATA, w);
        end
        rd_chk(pixel_path_pkg::REG_TABLE_INDEX, 32'h1, 1'b0);
        rd_chk(pixel_path_pkg::REG_SHADE_INDEX, 32'h1, 1'b0);
        rd_chk(pixel_path_pkg::REG_TABLE_DATA, 32'h0, 1'b0);
        for (int i = 0; i < 16; i++) begin
            ctrl = {25'h0, 3'(i % 8), 2'b00, i[0], 1'(i >= 8)};
            apb(1'b1, pixel_path_pkg::REG_CTRL, ctrl);
            rd_chk(pixel_path_pkg::REG_CTRL, ctrl, 1'b0);
            src.send_frame(i[1]);
            src.send_frame(i[2]);
            drain;
            $display("test %0d done", i + 1);
        end
        rd_chk(pixel_path_pkg::REG_STATUS, 32'd32, 1'b0);
        // Arrays must survive a reset
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        frames = '0;
        rd_chk(pixel_path_pkg::REG_CTRL, 32'h0, 1'b0);
        ctrl = 32'h3;
        apb(1'b1, pixel_path_pkg::REG_CTRL, ctrl);
        src.send_frame(1'b1);
        drain;
        $display("test 17 done");
        complete_run;
    end
endmodule // pixel_lut_shading_pattern_path_tb_top

`default_nettype wire
